//--- hw/lin_regs_pkg.sv
// Purpose: shared constants for the LIN error, size and baud registers.
// Assumes: AXI4-Lite access, one aligned word per register.
// Notes: the byte address of a register is four times its index.
package lin_regs_pkg;
    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int FRAME_MAX_US = 10000;
    localparam int FRAME_MAX_CYC_DEF = FRAME_MAX_US * CLK_MHZ;
    localparam int RESP_MAX_US = 5000;
    localparam int RESP_MAX_CYC_DEF = RESP_MAX_US * CLK_MHZ;
    // -------------------------------------------------------------
    // Register indices and fields
    // -------------------------------------------------------------
    localparam logic [3:0] IDX_CTRL = 4'h8;
    localparam logic [3:0] IDX_STAT = 4'h9;
    localparam logic [3:0] IDX_ERR = 4'ha;
    localparam logic [3:0] IDX_SIZE = 4'hb;
    localparam logic [3:0] IDX_DIV = 4'hc;
    localparam logic [3:0] IDX_SCALE = 4'hd;
    localparam int ERR_SYNC = 4;
    localparam int ERR_PAR = 3;
    localparam int ERR_TO = 2;
    localparam int ERR_CHK = 1;
    localparam int ERR_BIT = 0;
    localparam int SIZE_ENH = 7;
    localparam int SCALE_BAUD_DIVIDER_MSB = 0;
    localparam int CTRL_MASTER = 0;
    localparam int CTRL_RESP = 1;
    localparam int CTRL_CLR = 2;
    localparam int CTRL_DACK = 4;
    localparam int CTRL_STOP = 7;
    localparam int STAT_ERR = 2;
    localparam int STAT_ACT = 7;
    localparam logic [3:0] LEN_MAX = 4'h8;
    localparam logic [3:0] LEN_AUTO = 4'hf;
    localparam logic [7:0] ERR_RST = 8'h00;
    localparam logic [7:0] SIZE_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'hff;
    localparam logic [7:0] SCALE_RST = 8'hff;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_PID = 4'h2,
        PH_DATA = 4'h4,
        PH_CHK = 4'h8
    } phase_t;
endpackage

//--- hw/lin_error_size_baud_regs.sv
// Purpose: LIN error flags, frame length, checksum and baud settings.
// Assumes: a frame engine feeds received bytes after the sync field.
// Notes: the bus pin is synchronised here before the bit monitor.
`timescale 1ns/1ps
`default_nettype none
module lin_error_size_baud_regs
    import lin_regs_pkg::*;
#(
    parameter int FRAME_MAX_CYC = FRAME_MAX_CYC_DEF,
    parameter int RESP_MAX_CYC = RESP_MAX_CYC_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic lin_rx_pin,
    input wire logic tx_active,
    input wire logic tx_bit,
    input wire logic bit_sample,
    input wire logic sync_tol_fail,
    input wire logic frame_start,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_valid,
    output logic rx_byte_ready,
    output logic [7:0] rx_data,
    output logic rx_data_valid,
    input wire logic rx_data_ready,
    output logic master_mode,
    output logic frame_active,
    output logic [1:0] baud_prescaler,
    output logic [4:0] baud_multiplier,
    output logic [8:0] baud_divider
);
    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [7:0] wdata;
        logic wstb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [4:0] err;
        logic summary;
        logic enh;
        logic [3:0] len;
        logic [7:0] divlo;
        logic [7:0] scale;
        logic [4:0] mul_out;
        logic master;
        logic resp_exp;
        logic dack;
        logic stop;
        logic rx_s1;
        logic rx_s2;
        phase_t phase;
        logic first;
        logic [3:0] left;
        logic [7:0] sum;
        logic [7:0] pid;
        logic [23:0] fcnt;
        logic [23:0] gcnt;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [1:0] bcnt;
        logic rdy;
        logic dvalid;
        logic act;
    } state_t;

    state_t q;
    state_t d;
    logic [4:0] ev;
    logic [7:0] rd;
    logic [7:0] sum_nx;
    logic [3:0] len_now;
    logic take;
    logic chk_bad;
    logic clr;
    logic wr_do;
    logic wr_sel;
    logic resp_wait;

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    // Code 15 defers to the identifier; reserved codes clamp to eight.
    function automatic logic [3:0] data_len(input logic [3:0] code,
                                            input logic [1:0] idb);
        logic [3:0] n;
        n = code;
        if (code == LEN_AUTO) begin
            unique case (idb)
                2'b00: n = 4'h2;
                2'b01: n = 4'h2;
                2'b10: n = 4'h4;
                2'b11: n = 4'h8;
            endcase
        end else if (code > LEN_MAX) begin
            n = LEN_MAX;
        end
        return n;
    endfunction

    // Add with end-around carry; the sum cannot overflow twice.
    function automatic logic [7:0] csum_add(input logic [7:0] a,
                                            input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, a} + {1'b0, b};
        return t[7:0] + {7'h00, t[8]};
    endfunction

    function automatic logic pid_ok(input logic [7:0] p);
        return (p[6] == (p[0] ^ p[1] ^ p[2] ^ p[4]))
            && (p[7] == !(p[1] ^ p[3] ^ p[4] ^ p[5]));
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        return (a[7:6] == 2'h0) && (a[5:2] >= IDX_CTRL)
            && (a[5:2] <= IDX_SCALE);
    endfunction

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        d = q;
        ev = 5'h00;
        rd = 8'h00;
        // Register bus write side; the write lands once both halves are in.
        wr_do = q.aw_got && q.w_got && !q.bvalid;
        wr_sel = wr_do && q.wstb && reg_hit(q.waddr);
        clr = wr_sel && (q.waddr[5:2] == IDX_CTRL) && q.wdata[CTRL_CLR];
        if (q.awready && awvalid) begin
            d.aw_got = 1'b1;
            d.waddr = awaddr;
        end
        if (q.wready && wvalid) begin
            d.w_got = 1'b1;
            d.wdata = wdata[7:0];
            d.wstb = wstrb[0];
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_do) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = reg_hit(q.waddr) ? RESP_OKAY : RESP_SLVERR;
        end
        d.awready = !d.aw_got && !d.bvalid;
        d.wready = !d.w_got && !d.bvalid;

        // Register bus read side; data are captured when the address is taken.
        case (araddr[5:2])
            IDX_CTRL: begin
                rd[CTRL_MASTER] = q.master;
                rd[CTRL_RESP] = q.resp_exp;
                rd[CTRL_DACK] = q.dack;
                rd[CTRL_STOP] = q.stop;
            end
            IDX_STAT: begin
                rd[STAT_ERR] = q.summary;
                rd[STAT_ACT] = q.act;
            end
            IDX_ERR: rd = {3'b000, q.err};
            IDX_SIZE: rd = {q.enh, 3'b000, q.len};
            IDX_DIV: rd = q.divlo;
            IDX_SCALE: rd = q.scale;
            default: rd = 8'h00;
        endcase
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (q.arready && arvalid) begin
            d.rvalid = 1'b1;
            d.rresp = reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
            d.rdata = reg_hit(araddr) ? rd : 8'h00;
        end
        d.arready = !d.rvalid;

        // Bus monitor and sync check run apart from the byte stream.
        d.rx_s1 = lin_rx_pin;
        d.rx_s2 = q.rx_s1;
        if (sync_tol_fail && !q.master) begin
            ev[ERR_SYNC] = 1'b1;
        end
        if (tx_active && bit_sample && (q.rx_s2 != tx_bit)) begin
            ev[ERR_BIT] = 1'b1;
        end

        // Drain the two-entry buffer before any push this cycle.
        if (q.dvalid && rx_data_ready) begin
            d.b0 = q.b1;
            d.bcnt = q.bcnt - 2'h1;
        end

        // Frame sequencing over identifier, data and checksum bytes.
        take = rx_byte_valid && q.rdy;
        len_now = data_len(q.len, rx_byte[5:4]);
        sum_nx = csum_add(q.sum, rx_byte);
        chk_bad = (sum_nx != 8'hff);
        resp_wait = q.resp_exp && ((q.phase == PH_DATA) || (q.phase == PH_CHK));
        if (q.phase != PH_IDLE) begin
            d.fcnt = q.fcnt + 24'h00_0001;
        end
        if (resp_wait) begin
            d.gcnt = q.gcnt + 24'h00_0001;
        end
        unique case (q.phase)
            PH_IDLE: begin
            end
            PH_PID: begin
                if (take) begin
                    d.pid = rx_byte;
                    d.left = len_now;
                    d.first = 1'b1;
                    d.gcnt = 24'h00_0000;
                    d.sum = q.enh ? rx_byte : 8'h00;
                    d.phase = (len_now == 4'h0) ? PH_CHK : PH_DATA;
                    if (!q.master && !pid_ok(rx_byte)) begin
                        ev[ERR_PAR] = 1'b1;
                    end
                end
            end
            PH_DATA: begin
                if (take) begin
                    d.first = 1'b0;
                    d.sum = sum_nx;
                    d.left = q.left - 4'h1;
                    d.gcnt = 24'h00_0000;
                    // Software had until this byte to acknowledge or stop.
                    if (q.first && !q.master && !(q.dack || q.stop)) begin
                        ev[ERR_TO] = 1'b1;
                    end
                    if (q.left == 4'h1) begin
                        d.phase = PH_CHK;
                    end
                    if (d.bcnt == 2'h0) begin
                        d.b0 = rx_byte;
                    end else begin
                        d.b1 = rx_byte;
                    end
                    d.bcnt = d.bcnt + 2'h1;
                end
            end
            PH_CHK: begin
                if (take) begin
                    if (chk_bad) begin
                        ev[ERR_CHK] = 1'b1;
                    end
                    d.phase = PH_IDLE;
                end
            end
        endcase

        // Timeouts abandon the frame so a stuck bus cannot wedge the block.
        if ((q.phase != PH_IDLE) && (q.fcnt == 24'(FRAME_MAX_CYC - 1))) begin
            ev[ERR_TO] = 1'b1;
            d.phase = PH_IDLE;
        end
        if (resp_wait && (q.gcnt == 24'(RESP_MAX_CYC - 1))) begin
            ev[ERR_TO] = 1'b1;
            d.phase = PH_IDLE;
        end
        if (frame_start) begin
            d.phase = PH_PID;
            d.fcnt = 24'h00_0000;
            d.gcnt = 24'h00_0000;
            d.dack = 1'b0;
            d.stop = 1'b0;
        end

        // Software writes come last so a set by software beats the frame reset.
        if (wr_sel) begin
            case (q.waddr[5:2])
                IDX_SIZE: begin
                    d.enh = q.wdata[SIZE_ENH];
                    d.len = q.wdata[3:0];
                end
                IDX_DIV: d.divlo = q.wdata;
                IDX_SCALE: d.scale = q.wdata;
                IDX_CTRL: begin
                    d.master = q.wdata[CTRL_MASTER];
                    d.resp_exp = q.wdata[CTRL_RESP];
                    d.dack = q.wdata[CTRL_DACK];
                    d.stop = q.wdata[CTRL_STOP];
                end
                default: begin
                end
            endcase
        end

        // Flags: a new event in the clearing cycle survives the clear.
        d.err = (clr ? 5'h00 : q.err) | ev;
        d.summary = (clr ? 1'b0 : q.summary) | (|ev);
        d.mul_out = d.master ? d.scale[5:1] : 5'h00;
        d.act = (d.phase != PH_IDLE);
        d.rdy = (d.bcnt != 2'h2);
        d.dvalid = (d.bcnt != 2'h0);
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.phase <= PH_IDLE;
            q.err <= ERR_RST[4:0];
            q.enh <= SIZE_RST[SIZE_ENH];
            q.len <= SIZE_RST[3:0];
            q.divlo <= DIV_RST;
            q.scale <= SCALE_RST;
            q.master <= CTRL_RST[CTRL_MASTER];
            q.resp_exp <= CTRL_RST[CTRL_RESP];
            q.dack <= CTRL_RST[CTRL_DACK];
            q.stop <= CTRL_RST[CTRL_STOP];
        end else begin
            q <= d;
        end
    end

    // Outputs taken straight from the state.
    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = {24'h00_0000, q.rdata};
    assign rx_byte_ready = q.rdy;
    assign rx_data = q.b0;
    assign rx_data_valid = q.dvalid;
    assign master_mode = q.master;
    assign frame_active = q.act;
    assign baud_prescaler = q.scale[7:6];
    assign baud_multiplier = q.mul_out;
    assign baud_divider = {q.scale[SCALE_BAUD_DIVIDER_MSB], q.divlo};

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_err_unused;
        (q.arready && arvalid && (araddr == {2'b00, IDX_ERR, 2'b00}))
            |=> (rvalid && (rdata[7:5] == 3'b000));
    endproperty
    a_err_unused: assert property (p_err_unused)
        else $error("error register unused bits not zero");

    property p_sync;
        (sync_tol_fail && !q.master) |=> q.err[ERR_SYNC];
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync error not flagged");

    property p_par;
        (take && (q.phase == PH_PID) && !q.master && !pid_ok(rx_byte))
            |=> q.err[ERR_PAR];
    endproperty
    a_par: assert property (p_par)
        else $error("parity error not flagged");

    property p_resp_to;
        (resp_wait && !frame_start && (q.gcnt == 24'(RESP_MAX_CYC - 1)))
            |=> (q.err[ERR_TO] && (q.phase == PH_IDLE));
    endproperty
    a_resp_to: assert property (p_resp_to)
        else $error("response timeout not flagged");

    property p_frame_to;
        ((q.phase != PH_IDLE) && (q.fcnt == 24'(FRAME_MAX_CYC - 1)))
            |=> q.err[ERR_TO];
    endproperty
    a_frame_to: assert property (p_frame_to)
        else $error("frame timeout not flagged");

    property p_ack;
        (take && (q.phase == PH_DATA) && q.first && !q.master && !q.dack && !q.stop)
            |=> q.err[ERR_TO];
    endproperty
    a_ack: assert property (p_ack)
        else $error("missing acknowledge not flagged");

    property p_chk;
        (take && (q.phase == PH_CHK) && chk_bad)
            |=> q.err[ERR_CHK] ##1 (q.err[ERR_CHK] || $past(clr));
    endproperty
    a_chk: assert property (p_chk)
        else $error("checksum error not flagged");

    property p_bit;
        (tx_active && bit_sample && (q.rx_s2 != tx_bit)) |=> q.err[ERR_BIT];
    endproperty
    a_bit: assert property (p_bit)
        else $error("bit mismatch not flagged");

    property p_enh;
        (take && (q.phase == PH_PID) && !frame_start)
            |=> (q.sum == ($past(q.enh) ? $past(rx_byte) : 8'h00));
    endproperty
    a_enh: assert property (p_enh)
        else $error("checksum seed wrong for selected type");

    property p_auto_len;
        (take && (q.phase == PH_PID) && !frame_start && (q.len == LEN_AUTO)
            && (rx_byte[5:4] == 2'b11)) |=> (q.left == 4'h8);
    endproperty
    a_auto_len: assert property (p_auto_len)
        else $error("automatic length wrong");

    property p_div;
        (wr_sel && (q.waddr[5:2] == IDX_DIV)) |=> (baud_divider[7:0] == $past(q.wdata));
    endproperty
    a_div: assert property (p_div)
        else $error("divider low byte not applied");

    property p_mul;
        !master_mode |-> (baud_multiplier == 5'h00);
    endproperty
    a_mul: assert property (p_mul)
        else $error("multiplier used in slave mode");

    property p_summary;
        (q.summary && !clr) |=> q.summary;
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary error dropped without clear");
endmodule
`default_nettype wire

//--- tb/lin_node_model.sv
// Purpose: far-side LIN node feeding frame events and bytes to the block.
// Assumes: bytes arrive after the sync field, one per handshake.
// Notes: corrupt flips the echoed bus level to provoke a monitor fault.
`timescale 1ns/1ps
`default_nettype none
module lin_node_model (
    input wire logic aclk,
    input wire logic tx_active,
    input wire logic tx_bit,
    input wire logic rx_byte_ready,
    output logic lin_rx_pin,
    output logic frame_start,
    output logic sync_tol_fail,
    output logic [7:0] rx_byte,
    output logic rx_byte_valid
);
    logic corrupt = 1'h0;
    // The bus has a pull-up, so it rests recessive when nobody drives it.
    assign lin_rx_pin = tx_active ? (tx_bit ^ corrupt) : 1'h1;
    initial begin
        frame_start = 1'h0;
        sync_tol_fail = 1'h0;
        rx_byte = 8'h00;
        rx_byte_valid = 1'h0;
    end
    // A break pulse opens the frame.
    task automatic start();
        @(posedge aclk);
        frame_start <= 1'h1;
        @(posedge aclk);
        frame_start <= 1'h0;
    endtask
    // A sync field with edges out of tolerance.
    task automatic sync_bad();
        @(posedge aclk);
        sync_tol_fail <= 1'h1;
        @(posedge aclk);
        sync_tol_fail <= 1'h0;
    endtask
    // Byte held until taken; the lines then show the inverse, not stale data.
    task automatic send(input logic [7:0] b);
        @(posedge aclk);
        rx_byte <= b;
        rx_byte_valid <= 1'h1;
        for (int n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (rx_byte_ready) break;
        end
        rx_byte_valid <= 1'h0;
        rx_byte <= ~b;
        if (!rx_byte_ready) testbench.hang();
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Purpose: self-checking bench for the LIN error, size and baud registers.
// Assumes: short timeout parameters keep the run brief.
// Notes: register rows first, then frame cases and a mid-run reset.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import lin_regs_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [7:0] A_STAT = {2'h0, IDX_STAT, 2'h0};
    localparam logic [7:0] A_ERR = {2'h0, IDX_ERR, 2'h0};
    localparam logic [7:0] A_SIZE = {2'h0, IDX_SIZE, 2'h0};
    localparam logic [7:0] A_DIV = {2'h0, IDX_DIV, 2'h0};
    localparam logic [7:0] A_SCALE = {2'h0, IDX_SCALE, 2'h0};
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wd;
        logic [7:0] exp;
        logic [1:0] resp;
    } row_t;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic tx_active = 1'h0, tx_bit = 1'h1, bit_sample = 1'h0, rx_data_ready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, rx_byte_ready, rx_data_valid;
    logic lin_rx_pin, sync_tol_fail, frame_start, rx_byte_valid, master_mode, frame_active;
    logic [1:0] bresp, rresp, baud_prescaler, rd_resp, wr_resp;
    logic [31:0] rdata, rd_val;
    logic [7:0] rx_byte, rx_data;
    logic [4:0] baud_multiplier;
    logic [8:0] baud_divider;
    int num_errors = 0;
    int checks = 0;
    // Register rows: address, write flag, write data, read-back, response.
    row_t rows [9] = '{
        '{A_ERR, 1'h0, 8'h00, ERR_RST, RESP_OKAY},
        '{A_SIZE, 1'h0, 8'h00, SIZE_RST, RESP_OKAY},
        '{A_DIV, 1'h0, 8'h00, DIV_RST, RESP_OKAY},
        '{A_SCALE, 1'h0, 8'h00, SCALE_RST, RESP_OKAY},
        '{A_ERR, 1'h1, 8'hff, 8'h00, RESP_OKAY},
        '{A_SIZE, 1'h1, 8'hff, 8'h8f, RESP_OKAY},
        '{A_DIV, 1'h1, 8'h5a, 8'h5a, RESP_OKAY},
        '{A_SCALE, 1'h1, 8'ha7, 8'ha7, RESP_OKAY},
        '{8'h3c, 1'h0, 8'h00, 8'h00, RESP_SLVERR}};
    always #2.5 aclk = ~aclk;
    lin_error_size_baud_regs #(.FRAME_MAX_CYC(200), .RESP_MAX_CYC(100)) dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .lin_rx_pin(lin_rx_pin), .tx_active(tx_active), .tx_bit(tx_bit),
        .bit_sample(bit_sample), .sync_tol_fail(sync_tol_fail), .frame_start(frame_start),
        .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
        .rx_data(rx_data), .rx_data_valid(rx_data_valid), .rx_data_ready(rx_data_ready),
        .master_mode(master_mode), .frame_active(frame_active),
        .baud_prescaler(baud_prescaler), .baud_multiplier(baud_multiplier),
        .baud_divider(baud_divider));
    lin_node_model node (
        .aclk(aclk), .tx_active(tx_active), .tx_bit(tx_bit),
        .rx_byte_ready(rx_byte_ready), .lin_rx_pin(lin_rx_pin), .frame_start(frame_start),
        .sync_tol_fail(sync_tol_fail), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic hang();
        chk("handshake", 32'h0000_0001, 32'h0000_0000);
        report_and_stop();
    endtask
    // Both halves offered together; each dropped once taken, bready held high.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        wr_resp = bresp;
        if (n == 50) hang();
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rd_val = rdata;
        rd_resp = rresp;
        if (n == 50) hang();
    endtask
    // Waits for one buffered data byte; the caller holds rx_data_ready high.
    task automatic pop(input logic [7:0] e);
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (rx_data_valid) break;
        end
        chk("rx_data", 32'(e), 32'(rx_data));
        if (n == 50) hang();
    endtask
    // Slave frame: break, optional acknowledge, identifier and data bytes 1..n.
    task automatic frame(input logic [7:0] pid, input int n, input logic ack);
        node.start();
        wr(A_CTRL, {3'h0, ack, 4'h0});
        node.send(pid);
        for (int i = 1; i <= n; i++) node.send(8'(i));
    endtask
    task automatic err_is(input string name, input logic [7:0] e);
        repeat (2) @(posedge aclk);
        rd(A_ERR);
        chk(name, 32'(e), rd_val);
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].addr, rows[i].wd);
            rd(rows[i].addr);
            chk("reg", 32'(rows[i].exp), rd_val);
            chk("resp", 32'(rows[i].resp), 32'(rd_resp));
        end
        // A write without its low strobe is answered but changes nothing.
        wstrb <= 4'h0;
        wr(A_DIV, 8'h11);
        wstrb <= 4'hf;
        chk("bresp", 32'(RESP_OKAY), 32'(wr_resp));
        chk("divider", 32'h0000_015a, 32'(baud_divider));
        chk("prescaler", 32'h0000_0002, 32'(baud_prescaler));
        chk("mult_slave", 32'h0000_0000, 32'(baud_multiplier));
        wr(A_CTRL, 8'h01);
        chk("mult_master", 32'h0000_0013, 32'(baud_multiplier));
        chk("master", 32'h0000_0001, 32'(master_mode));
        // Receiver stalls: two data bytes fill the buffer and hold the checksum.
        wr(A_SIZE, 8'h02);
        frame(8'h80, 2, 1'h1);
        repeat (3) @(posedge aclk);
        chk("byte_ready", 32'h0000_0000, 32'(rx_byte_ready));
        chk("active", 32'h0000_0001, 32'(frame_active));
        fork
            node.send(8'hfc);
        join_none
        rx_data_ready <= 1'h1;
        pop(8'h01);
        pop(8'h02);
        err_is("err_classic", 8'h00);
        // Automatic length from identifier bits: four bytes, enhanced sum.
        wr(A_SIZE, 8'h8f);
        frame(8'h20, 4, 1'h1);
        node.send(8'hd5);
        err_is("err_enhanced", 8'h00);
        frame(8'h20, 4, 1'h1);
        node.send(8'hf5);
        err_is("err_checksum", 8'h02);
        rd(A_STAT);
        chk("summary", 32'h0000_0001, 32'(rd_val[STAT_ERR]));
        wr(A_CTRL, 8'h04);
        rd(A_STAT);
        chk("summary_clr", 32'h0000_0000, 32'(rd_val[STAT_ERR]));
        // Slave: bad parity, bad sync, then no data until the frame limit.
        wr(A_SIZE, 8'h02);
        node.start();
        node.send(8'h00);
        err_is("err_parity", 8'h08);
        node.sync_bad();
        err_is("err_sync", 8'h18);
        repeat (250) @(posedge aclk);
        err_is("err_frame_time", 8'h1c);
        wr(A_CTRL, 8'h04);
        // First data byte arrives with neither acknowledge nor stop set.
        node.start();
        node.send(8'h80);
        node.send(8'h01);
        err_is("err_no_ack", 8'h04);
        wr(A_CTRL, 8'h04);
        // Master waits for a silent responder; parity and sync are ignored.
        wr(A_CTRL, 8'h03);
        node.start();
        node.send(8'h00);
        node.sync_bad();
        repeat (120) @(posedge aclk);
        err_is("err_master", 8'h04);
        wr(A_CTRL, 8'h05);
        // Own transmitter drives dominant while the bus reads recessive.
        tx_active <= 1'h1;
        tx_bit <= 1'h0;
        node.corrupt <= 1'h1;
        repeat (4) @(posedge aclk);
        bit_sample <= 1'h1;
        @(posedge aclk);
        bit_sample <= 1'h0;
        tx_active <= 1'h0;
        err_is("err_bit", 8'h01);
        // A reset in mid-run restores the baud settings.
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        chk("div_rst", 32'h0000_01ff, 32'(baud_divider));
        chk("mult_rst", 32'h0000_0000, 32'(baud_multiplier));
        report_and_stop();
    end
endmodule
`default_nettype wire
